// ==== rtl/hmf_pkg.sv ====
// Package with register map, field positions, reset values and sizing for the MAC FIFO control block
package hmf_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TRANSMIT_CONFIG       = 8'h70;
  localparam logic [7:0] OFS_RECEIVE_PATH_CONTROL  = 8'h78;
  localparam logic [7:0] OFS_RECEIVE_FIFO_LEVELS   = 8'h7c;
  localparam logic [7:0] OFS_TRANSMIT_FIFO_LEVELS  = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_TX_STATUS_PURGE       = 15;
  localparam int BIT_TX_DATA_PURGE         = 14;
  localparam int BIT_STATUS_OVERRUN_PERMIT = 2;
  localparam int BIT_TX_ENABLE             = 1;
  localparam int BIT_TX_STOP               = 0;
  localparam int BIT_RX_FRAME_SKIP         = 31;
  localparam int LEVEL_WORDS_LSB           = 16;   // Status word count, bits 23:16
  localparam int LEVEL_WORDS_W             = 8;
  localparam int LEVEL_BYTES_W             = 16;   // Byte count, bits 15:0

  // ----------------------------------------------------------------
  // Reset values and sizing
  // ----------------------------------------------------------------
  localparam logic [15:0] TX_DATA_CAPACITY  = 16'h1200;  // Free bytes of an empty transmit data FIFO
  localparam int          TX_STATUS_DEPTH   = 128;       // Transmit status FIFO words
  localparam logic [15:0] BYTES_PER_WORD    = 16'h0004;
  localparam logic [31:0] RDATA_RESET       = 32'h00000000;

endpackage : hmf_pkg

// ==== rtl/hmf_fifo_control.sv ====
// Control and status registers for the host MAC transmit and receive FIFOs
`timescale 1ns/1ps
`default_nettype none

module hmf_fifo_control #(
  parameter int TXS_DEPTH   = hmf_pkg::TX_STATUS_DEPTH,
  parameter int TXD_BYTES   = 32'(hmf_pkg::TX_DATA_CAPACITY)
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  // Register port of the host interface
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [31:0] REG_WDATA,
  output logic [31:0]      REG_RDATA,
  output logic             REG_RVALID,
  // Transmit data FIFO events, one word each
  input  wire logic        TXD_PUSH,
  input  wire logic        TXD_POP,
  // Transmit status FIFO events
  input  wire logic        TXS_PUSH,
  input  wire logic        TXS_POP,
  // Receive status FIFO events
  input  wire logic        RXS_PUSH,
  input  wire logic        RXS_POP,
  // Receive data FIFO events
  input  wire logic        RXD_FRAME_DONE,
  input  wire logic [15:0] RXD_FRAME_LEN,
  input  wire logic        RXD_POP,
  input  wire logic        RX_SKIP_DONE,
  input  wire logic [15:0] RX_SKIP_BYTES,
  // Transmitter handshake and datapath commands
  input  wire logic        TX_IDLE,
  output logic             TX_RUN,
  output logic             TX_STOP_REQ,
  output logic             TX_STATUS_FULL,
  output logic             TXS_PURGE,
  output logic             TXD_PURGE,
  output logic             RX_SKIP_REQ
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Refuse sizes that the level fields or the word-granular free count cannot hold
  generate
    if (TXS_DEPTH < 1 || TXS_DEPTH > 255) begin : g_bad_txs
      $error("TXS_DEPTH must fit the 8-bit level field");
    end
    if (TXD_BYTES < 4 || TXD_BYTES > 65535 || (TXD_BYTES % 4) != 0) begin : g_bad_txd
      $error("TXD_BYTES must be a whole number of words within 16 bits");
    end
    if (hmf_pkg::LEVEL_WORDS_LSB + hmf_pkg::LEVEL_WORDS_W > 32) begin : g_bad_layout
      $error("Level word field must fit the 32-bit register");
    end
  endgenerate

  // Level and free-count forms of the parameters
  localparam logic [7:0]  TXS_FULL_LEVEL = 8'(TXS_DEPTH);
  localparam logic [15:0] TXD_EMPTY_FREE = 16'(TXD_BYTES);

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic        status_overrun_permit;
  logic        tx_enable;
  logic        tx_stop;
  logic        rx_frame_skip;
  logic        next_status_overrun_permit;
  logic        next_tx_enable;
  logic        next_tx_stop;
  logic        next_rx_frame_skip;
  logic        wr_tx_cfg;
  logic        wr_rx_ctrl;
  logic        txs_purge_req;
  logic        txd_purge_req;

  // Decoded write strobes; purge requests are pure write events
  // Reserved bits of either register feed no logic at all
  assign wr_tx_cfg     = REG_WR && (REG_ADDR == hmf_pkg::OFS_TRANSMIT_CONFIG);
  assign wr_rx_ctrl    = REG_WR && (REG_ADDR == hmf_pkg::OFS_RECEIVE_PATH_CONTROL);
  assign txs_purge_req = wr_tx_cfg && REG_WDATA[hmf_pkg::BIT_TX_STATUS_PURGE];
  assign txd_purge_req = wr_tx_cfg && REG_WDATA[hmf_pkg::BIT_TX_DATA_PURGE];

  // Next values of the control bits
  always_comb begin
    next_status_overrun_permit = status_overrun_permit;
    next_tx_enable             = tx_enable;
    next_tx_stop               = tx_stop;
    next_rx_frame_skip         = rx_frame_skip;
    if (wr_tx_cfg) begin
      next_status_overrun_permit = REG_WDATA[hmf_pkg::BIT_STATUS_OVERRUN_PERMIT];
      next_tx_enable             = REG_WDATA[hmf_pkg::BIT_TX_ENABLE];
    end
    // Stop completes only when the transmitter reports it is between frames
    // Hardware clearing outranks a software enable write in the same cycle
    if (tx_stop && TX_IDLE) begin
      next_tx_stop   = 1'b0;
      next_tx_enable = 1'b0;
    end else if (wr_tx_cfg && !tx_stop) begin
      next_tx_stop = REG_WDATA[hmf_pkg::BIT_TX_STOP];
    end
    // A new request in the cycle the old one finishes is kept, not lost
    if (wr_rx_ctrl && REG_WDATA[hmf_pkg::BIT_RX_FRAME_SKIP]) begin
      next_rx_frame_skip = 1'b1;
    end else if (RX_SKIP_DONE) begin
      next_rx_frame_skip = 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      status_overrun_permit <= 1'b0;
      tx_enable             <= 1'b0;
      tx_stop               <= 1'b0;
      rx_frame_skip         <= 1'b0;
    end else begin
      status_overrun_permit <= next_status_overrun_permit;
      tx_enable             <= next_tx_enable;
      tx_stop               <= next_tx_stop;
      rx_frame_skip         <= next_rx_frame_skip;
    end
  end

  // ----------------------------------------------------------------
  // FIFO level tracking
  // ----------------------------------------------------------------
  logic [7:0]  tx_status_words_used;
  logic [7:0]  rx_status_words_used;
  logic [15:0] tx_data_bytes_free;
  logic [15:0] rx_data_bytes_used;
  logic [7:0]  next_tx_status_words_used;
  logic [7:0]  next_rx_status_words_used;
  logic [15:0] next_tx_data_bytes_free;
  logic [15:0] next_rx_data_bytes_used;
  logic [15:0] rx_frame_rounded;

  // Partial last words occupy a whole word in the FIFO
  assign rx_frame_rounded = {RXD_FRAME_LEN[15:2] + 14'(|RXD_FRAME_LEN[1:0]), 2'b00};

  // Next levels; a purge overrides any event in the same cycle so the next read shows empty
  always_comb begin
    next_tx_status_words_used = tx_status_words_used;
    next_rx_status_words_used = rx_status_words_used;
    next_tx_data_bytes_free   = tx_data_bytes_free;
    next_rx_data_bytes_used   = rx_data_bytes_used;
    if (txs_purge_req) begin
      next_tx_status_words_used = 8'h00;
    end else if (TXS_PUSH && !TXS_POP) begin
      next_tx_status_words_used = tx_status_words_used + 8'h01;
    end else if (TXS_POP && !TXS_PUSH) begin
      next_tx_status_words_used = tx_status_words_used - 8'h01;
    end
    if (txd_purge_req) begin
      next_tx_data_bytes_free = TXD_EMPTY_FREE;
    end else if (TXD_POP && !TXD_PUSH) begin
      next_tx_data_bytes_free = tx_data_bytes_free + hmf_pkg::BYTES_PER_WORD;
    end else if (TXD_PUSH && !TXD_POP) begin
      // Relies on the host honouring the free count, so no underflow guard
      next_tx_data_bytes_free = tx_data_bytes_free - hmf_pkg::BYTES_PER_WORD;
    end
    if (RXS_PUSH && !RXS_POP) begin
      next_rx_status_words_used = rx_status_words_used + 8'h01;
    end else if (RXS_POP && !RXS_PUSH) begin
      next_rx_status_words_used = rx_status_words_used - 8'h01;
    end
    // Receive data: frames add, host reads and skips subtract, all in one cycle
    if (RXD_FRAME_DONE) begin
      next_rx_data_bytes_used = next_rx_data_bytes_used + rx_frame_rounded;
    end
    if (RXD_POP) begin
      next_rx_data_bytes_used = next_rx_data_bytes_used - hmf_pkg::BYTES_PER_WORD;
    end
    if (RX_SKIP_DONE) begin
      next_rx_data_bytes_used = next_rx_data_bytes_used - RX_SKIP_BYTES;
    end
  end

  // Level registers
  // Counts wrap rather than saturate: the host and datapath must not overflow them
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_status_words_used <= 8'h00;
      rx_status_words_used <= 8'h00;
      tx_data_bytes_free   <= TXD_EMPTY_FREE;
      rx_data_bytes_used   <= 16'h0000;
    end else begin
      tx_status_words_used <= next_tx_status_words_used;
      rx_status_words_used <= next_rx_status_words_used;
      tx_data_bytes_free   <= next_tx_data_bytes_free;
      rx_data_bytes_used   <= next_rx_data_bytes_used;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter and datapath outputs
  // ----------------------------------------------------------------
  logic next_tx_run;
  logic next_tx_status_full;

  // Full compares the level that will be visible, so run and full move together
  always_comb begin
    next_tx_status_full = (next_tx_status_words_used >= TXS_FULL_LEVEL);
    next_tx_run         = next_tx_enable &&
                          (next_status_overrun_permit || !next_tx_status_full);
  end

  // Output flops; purge and skip commands are registered copies of their sources
  // Registering them keeps every output on a flop at the cost of one cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      TX_RUN         <= 1'b0;
      TX_STOP_REQ    <= 1'b0;
      TX_STATUS_FULL <= 1'b0;
      TXS_PURGE      <= 1'b0;
      TXD_PURGE      <= 1'b0;
      RX_SKIP_REQ    <= 1'b0;
    end else begin
      TX_RUN         <= next_tx_run;
      TX_STOP_REQ    <= next_tx_stop;
      TX_STATUS_FULL <= next_tx_status_full;
      TXS_PURGE      <= txs_purge_req;
      TXD_PURGE      <= txd_purge_req;
      RX_SKIP_REQ    <= next_rx_frame_skip;
    end
  end

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;
  logic        next_rvalid;

  // Read mux; purge bits are write-only and every reserved bit reads zero
  // Data holds between reads so a slow host can still pick it up late
  always_comb begin
    next_rdata  = REG_RDATA;
    next_rvalid = REG_RD;
    if (REG_RD) begin
      next_rdata = hmf_pkg::RDATA_RESET;
      case (REG_ADDR)
        hmf_pkg::OFS_TRANSMIT_CONFIG: begin
          next_rdata[hmf_pkg::BIT_STATUS_OVERRUN_PERMIT] = status_overrun_permit;
          next_rdata[hmf_pkg::BIT_TX_ENABLE]             = tx_enable;
          next_rdata[hmf_pkg::BIT_TX_STOP]               = tx_stop;
        end
        hmf_pkg::OFS_RECEIVE_PATH_CONTROL: begin
          next_rdata[hmf_pkg::BIT_RX_FRAME_SKIP] = rx_frame_skip;
        end
        hmf_pkg::OFS_RECEIVE_FIFO_LEVELS: begin
          next_rdata[hmf_pkg::LEVEL_WORDS_LSB +: hmf_pkg::LEVEL_WORDS_W] = rx_status_words_used;
          next_rdata[0 +: hmf_pkg::LEVEL_BYTES_W]                        = rx_data_bytes_used;
        end
        hmf_pkg::OFS_TRANSMIT_FIFO_LEVELS: begin
          next_rdata[hmf_pkg::LEVEL_WORDS_LSB +: hmf_pkg::LEVEL_WORDS_W] = tx_status_words_used;
          next_rdata[0 +: hmf_pkg::LEVEL_BYTES_W]                        = tx_data_bytes_free;
        end
        default: begin
          next_rdata = hmf_pkg::RDATA_RESET;
        end
      endcase
    end
  end

  // Read data is held until the next read
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA  <= hmf_pkg::RDATA_RESET;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RDATA  <= next_rdata;
      REG_RVALID <= next_rvalid;
    end
  end

endmodule : hmf_fifo_control

`default_nettype wire

// ==== dv/hmf_fifo_control_asserts.sv ====
// Concurrent checks on the MAC FIFO control block ports
`timescale 1ns/1ps
`default_nettype none
module hmf_fifo_control_asserts #(
  parameter int TXS_DEPTH = hmf_pkg::TX_STATUS_DEPTH,
  parameter int TXD_BYTES = 32'(hmf_pkg::TX_DATA_CAPACITY)
) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic        REG_RVALID,
  input wire logic        TXD_PUSH,
  input wire logic        TXD_POP,
  input wire logic        TX_IDLE,
  input wire logic        TX_RUN,
  input wire logic        TX_STOP_REQ,
  input wire logic        TX_STATUS_FULL,
  input wire logic        TXS_PURGE,
  input wire logic        TXD_PURGE,
  input wire logic        RX_SKIP_REQ,
  input wire logic        RX_SKIP_DONE,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA
);
  // ----------------------------------------
  // Decoded writes and permit shadow
  // ----------------------------------------
  logic wr_cfg, wr_skip, permit_q;
  assign wr_cfg  = REG_WR && REG_ADDR == hmf_pkg::OFS_TRANSMIT_CONFIG;
  assign wr_skip = REG_WR && REG_ADDR == hmf_pkg::OFS_RECEIVE_PATH_CONTROL && REG_WDATA[31];
  // Every config write rewrites the permit, so the shadow never drifts
  always_ff @(posedge CLK) begin
    if (RST) permit_q <= 1'b0;
    else if (wr_cfg) permit_q <= REG_WDATA[2];
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_txs_purge; wr_cfg && REG_WDATA[15] |=> TXS_PURGE; endproperty
  a_txs_purge: assert property (p_txs_purge) else $error("status purge pulse missing");
  property p_txd_purge; TXD_PURGE |-> $past(wr_cfg) && $past(REG_WDATA[14]); endproperty
  a_txd_purge: assert property (p_txd_purge) else $error("data purge pulse without cause");
  // Run and full are registered from the same next values, so they move on one edge
  property p_full_stall; TX_STATUS_FULL && !permit_q |-> !TX_RUN; endproperty
  a_full_stall: assert property (p_full_stall) else $error("transmitter runs with full status");
  property p_skip_set; wr_skip |=> RX_SKIP_REQ; endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip not started");
  property p_skip_hold; RX_SKIP_REQ && !wr_skip |=> RX_SKIP_REQ != $past(RX_SKIP_DONE); endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skip bit wrong around done");
  property p_stop_hold; TX_STOP_REQ && !TX_IDLE |=> TX_STOP_REQ; endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop dropped mid-frame");
  property p_stop_done; TX_STOP_REQ && TX_IDLE |=> !TX_STOP_REQ && !TX_RUN; endproperty
  a_stop_done: assert property (p_stop_done) else $error("stop or enable not cleared");
  property p_stop_lock; TX_STOP_REQ && !TX_IDLE && wr_cfg && !REG_WDATA[0] |=> TX_STOP_REQ; endproperty
  a_stop_lock: assert property (p_stop_lock) else $error("stop write not ignored");
  property p_rsvd; REG_RD && REG_ADDR != hmf_pkg::OFS_TRANSMIT_CONFIG
    && REG_ADDR != hmf_pkg::OFS_RECEIVE_PATH_CONTROL |=> REG_RVALID && REG_RDATA[31:24] == 8'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved level bits set");
  property p_cfg_rd; REG_RD && REG_ADDR == hmf_pkg::OFS_TRANSMIT_CONFIG |=> REG_RDATA[31:3] == 29'h0; endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config upper bits set");
  property p_purge_free; wr_cfg && REG_WDATA[14] ##1 !TXD_PUSH && !TXD_POP
    ##1 REG_RD && REG_ADDR == hmf_pkg::OFS_TRANSMIT_FIFO_LEVELS |=> REG_RDATA[15:0] == 16'(TXD_BYTES); endproperty
  a_purge_free: assert property (p_purge_free) else $error("free space not restored");
  c_purge: cover property (wr_cfg && REG_WDATA[14]);
  c_stop: cover property (TX_STOP_REQ && TX_IDLE);
  c_skip: cover property (RX_SKIP_REQ && RX_SKIP_DONE);
  c_full_run: cover property (TX_STATUS_FULL && permit_q && TX_RUN);
endmodule : hmf_fifo_control_asserts
bind hmf_fifo_control hmf_fifo_control_asserts #(.TXS_DEPTH(TXS_DEPTH), .TXD_BYTES(TXD_BYTES)) chk_u (.*);
`default_nettype wire

// ==== dv/hmf_tx_model.sv ====
// Transmitter model that consumes data words frame by frame
`timescale 1ns/1ps
`default_nettype none
module hmf_tx_model #(
  parameter int FLEN = 12
) (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic TX_RUN,
  input  wire logic TX_STOP_REQ,
  output logic      TX_IDLE,
  output logic      TXD_POP
);
  logic [3:0] left;
  int         words;
  // A frame starts only between frames, so a stop always lands on a boundary
  always_ff @(posedge CLK) begin
    if (RST) begin
      left    <= 4'h0;
      TXD_POP <= 1'b0;
      words   <= 0;
    end else begin
      TXD_POP <= 1'b0;
      if (left != 4'h0) left <= left - 4'h1;
      else if (TX_RUN && !TX_STOP_REQ) begin
        left    <= 4'(FLEN);
        TXD_POP <= 1'b1;
        words   <= words + 1;
      end
    end
  end
  assign TX_IDLE = left == 4'h0;
endmodule : hmf_tx_model
`default_nettype wire

// ==== dv/hmf_fifo_control_test.sv ====
// Self-checking testbench of the MAC FIFO control block
`timescale 1ns/1ps
`default_nettype none
module hmf_fifo_control_test;
  localparam int DEPTH = 4;  // Small status FIFO so full comes quickly
  logic        CLK, RST, REG_WR, REG_RD, REG_RVALID, TXD_PUSH, TXD_POP, TXS_PUSH, TXS_POP, RXS_PUSH;
  logic        RXS_POP, RXD_FRAME_DONE, RXD_POP, RX_SKIP_DONE, TX_IDLE, TX_RUN, TX_STOP_REQ;
  logic        TX_STATUS_FULL, TXS_PURGE, TXD_PURGE, RX_SKIP_REQ;
  logic [7:0]  REG_ADDR, evs;
  logic [15:0] RXD_FRAME_LEN, RX_SKIP_BYTES;
  logic [31:0] REG_WDATA, REG_RDATA;
  int          fails, cmp_count, n;
  assign {RX_SKIP_DONE, RXD_POP, RXD_FRAME_DONE, RXS_POP, RXS_PUSH, TXS_POP, TXS_PUSH, TXD_PUSH} = evs;
  hmf_fifo_control #(.TXS_DEPTH(DEPTH)) dut_u (.*);
  hmf_tx_model tx_u (.*);
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Each task leaves at a falling edge so outputs have settled for checks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
    @(posedge CLK);
    REG_WR <= 1'b0;
    @(negedge CLK);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK);
    {REG_RD, REG_ADDR} <= {1'b1, a};
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(negedge CLK);
    chk(32'(REG_RVALID), 32'h1);
    chk(REG_RDATA, exp);
  endtask : rd
  // Back-to-back event pulses, one unit per cycle
  task automatic ev(input logic [7:0] m, input int cnt);
    @(posedge CLK);
    repeat (cnt) begin
      evs <= m;
      @(posedge CLK);
    end
    evs <= 8'h00;
    @(negedge CLK);
  endtask : ev
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  // Watchdog well beyond the fewer than two hundred cycles the sequence needs
  initial begin
    repeat (3000) @(posedge CLK);
    fails++;
    print_verdict();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    RST = 1'b1;
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA, evs, fails, cmp_count} = '0;
    {RXD_FRAME_LEN, RX_SKIP_BYTES} = {16'h0005, 16'h0008};
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    rd(8'h80, 32'h00001200);
    rd(8'h7c, 32'h00000000);
    rd(8'h90, 32'h00000000);
    ev(8'h01, 2);
    ev(8'h02, 3);
    ev(8'h08, 2);
    ev(8'h20, 2);  // Two five-byte frames, each rounded up to two words
    ev(8'h50, 1);
    rd(8'h7c, 32'h0001000c);
    rd(8'h80, 32'h000311f8);
    wr(8'h78, 32'h80000000);
    chk(32'(RX_SKIP_REQ), 32'h1);
    rd(8'h78, 32'h80000000);
    ev(8'h80, 1);  // No data reads while the skip runs
    rd(8'h78, 32'h00000000);
    rd(8'h7c, 32'h00010004);
    wr(8'h70, 32'h0000c000);
    chk(32'({TXS_PURGE, TXD_PURGE}), 32'h3);
    rd(8'h80, 32'h00001200);
    chk(32'({TXS_PURGE, TXD_PURGE}), 32'h0);
    wr(8'h70, 32'hffff3ff8);
    wr(8'h7c, 32'hffffffff);
    rd(8'h70, 32'h00000000);
    rd(8'h7c, 32'h00010004);
    ev(8'h01, 6);
    ev(8'h02, 4);
    wr(8'h70, 32'h00000002);
    chk(32'(TX_RUN), 32'h0);
    chk(32'(TX_STATUS_FULL), 32'h1);
    wr(8'h70, 32'h00000006);
    chk(32'(TX_RUN), 32'h1);
    chk(32'(TX_STATUS_FULL), 32'h1);
    ev(8'h04, 1);
    @(negedge CLK);
    chk(32'(TX_STATUS_FULL), 32'h0);
    n = 0;
    while (!TXD_POP && n < 40) begin
      @(negedge CLK);
      n++;
    end
    chk(32'(TXD_POP), 32'h1);
    wr(8'h70, 32'h00000007);
    wr(8'h70, 32'h00000006);
    chk(32'(TX_STOP_REQ), 32'h1);
    rd(8'h70, 32'h00000007);
    while (TX_STOP_REQ && n < 80) begin
      @(negedge CLK);
      n++;
    end
    chk(32'(TX_STOP_REQ), 32'h0);
    chk(32'(TX_RUN), 32'h0);
    rd(8'h70, 32'h00000004);
    chk(32'(tx_u.words > 1), 32'h1);
    wr(8'h70, 32'h00004000);
    chk(32'({TXS_PURGE, TXD_PURGE}), 32'h1);
    rd(8'h80, 32'h00031200);
    print_verdict();
  end
endmodule : hmf_fifo_control_test
`default_nettype wire
